// ==== rtl/ldob_pkg.sv ====
package ldob_pkg;
  // Regulator slots inside the bank: 0..5 serve regulators 3..8
  localparam int unsigned NUM_REG = 6;
  localparam int unsigned SLOT_R3 = 0;
  localparam int unsigned SLOT_R4 = 1;
  localparam int unsigned SLOT_R5 = 2;
  localparam int unsigned SLOT_R6 = 3;
  localparam int unsigned SLOT_R7 = 4;
  localparam int unsigned SLOT_R8 = 5;

  // Control byte addresses
  localparam logic [7:0] OFF_REG3 = 8'h0c;
  localparam logic [7:0] OFF_REG5 = 8'h0d;
  localparam logic [7:0] OFF_REG7 = 8'h0e;
  localparam logic [7:0] OFF_REG4 = 8'h10;
  localparam logic [7:0] OFF_REG6 = 8'h11;
  localparam logic [7:0] OFF_REG8 = 8'h12;

  // Field layout of a control byte
  localparam int unsigned CODE_W   = 5;
  localparam int unsigned BIT_ON   = 5;
  localparam int unsigned BIT_OK   = 6;
  localparam int unsigned BIT_DIS  = 7;
  localparam int unsigned BAND_LSB = 3;

  // Values after reset
  localparam logic [4:0] RST_CODE = 5'h00;
  localparam logic       RST_ON   = 1'b0;
  localparam logic       RST_DIS  = 1'b0;

  // Voltage code: band base and step, in millivolts
  localparam int unsigned MV_W = 12;
  localparam logic [11:0] BAND0_BASE_MV = 12'h578;
  localparam logic [11:0] BAND1_BASE_MV = 12'h866;
  localparam logic [11:0] BAND2_BASE_MV = 12'h9f6;
  localparam logic [11:0] BAND3_BASE_MV = 12'hbb8;
  localparam logic [11:0] STEP_WIDE_MV  = 12'h064;
  localparam logic [11:0] STEP_FINE_MV  = 12'h032;
endpackage : ldob_pkg

// ==== rtl/ldob_vdecode.sv ====
`timescale 1ns/1ns
module ldob_vdecode
  import ldob_pkg::*;
(
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  // Code in, millivolts out
  input  wire logic [ldob_pkg::CODE_W-1:0] code,
  output logic      [ldob_pkg::MV_W-1:0]   target_mv
);
  import ldob_pkg::*;

  logic [MV_W-1:0] target_mv_ff;
  logic [MV_W-1:0] nxt_target_mv;
  logic [MV_W-1:0] step;
  logic [MV_W-1:0] base;
  logic [MV_W-1:0] prod;

  always_comb
  begin
    step = MV_W'(code[BAND_LSB-1:0]);
    unique case (code[CODE_W-1:BAND_LSB])
      2'b00:
      begin
        base = BAND0_BASE_MV;
        prod = MV_W'(step * STEP_WIDE_MV);
      end
      2'b01:
      begin
        base = BAND1_BASE_MV;
        prod = MV_W'(step * STEP_FINE_MV);
      end
      2'b10:
      begin
        base = BAND2_BASE_MV;
        prod = MV_W'(step * STEP_FINE_MV);
      end
      2'b11:
      begin
        base = BAND3_BASE_MV;
        prod = MV_W'(step * STEP_WIDE_MV);
      end
    endcase
    nxt_target_mv = target_mv_ff;
    if (clk_en)
    begin
      nxt_target_mv = MV_W'(base + prod);
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      target_mv_ff <= BAND0_BASE_MV;
    end
    else
    begin
      target_mv_ff <= nxt_target_mv;
    end
  end

  assign target_mv = target_mv_ff;
endmodule : ldob_vdecode

// ==== rtl/ldob_bank.sv ====
`timescale 1ns/1ns
module ldob_bank
  import ldob_pkg::*;
#(
  parameter int unsigned NREG = ldob_pkg::NUM_REG
)
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  // Register port behind the serial interface
  input  wire logic [7:0]             reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  output logic                        reg_rvalid,
  // Enable pins and sequencing
  input  wire logic                   startup_done,
  input  wire logic                   oscillator_rail_pin,
  input  wire logic                   rx_rail_pin,
  input  wire logic                   tx_rail_pin,
  input  wire logic                   power_keep_pin,
  // Regulator status, slot 0..5 = regulators 3..8
  input  wire logic [NREG-1:0]        in_regulation,
  // Regulator controls
  output logic      [NREG-1:0]        reg_enable,
  output logic      [NREG-1:0]        discharge_select,
  output logic [NREG-1:0][ldob_pkg::CODE_W-1:0] voltage_code,
  output logic [NREG-1:0][ldob_pkg::MV_W-1:0]   target_mv
);
  import ldob_pkg::*;

  logic [NREG-1:0][CODE_W-1:0] code_ff;
  logic [NREG-1:0][CODE_W-1:0] nxt_code;
  logic [NREG-1:0]             on_ff;
  logic [NREG-1:0]             nxt_on;
  logic [NREG-1:0]             dis_ff;
  logic [NREG-1:0]             nxt_dis;
  logic [NREG-1:0]             ok_ff;
  logic [NREG-1:0]             nxt_ok;
  logic [NREG-1:0]             en_ff;
  logic [NREG-1:0]             nxt_en;
  logic [NREG-1:0]             pin_req;
  logic [7:0]                  rdata_ff;
  logic [7:0]                  nxt_rdata;
  logic                        rvalid_ff;
  logic                        nxt_rvalid;
  logic                        wr_hit;
  logic                        rd_hit;
  logic [2:0]                  wr_slot;
  logic [2:0]                  rd_slot;

  function automatic logic [3:0] slot_of(input logic [7:0] addr);
    unique case (addr)
      OFF_REG3: slot_of = {1'b1, 3'(SLOT_R3)};
      OFF_REG4: slot_of = {1'b1, 3'(SLOT_R4)};
      OFF_REG5: slot_of = {1'b1, 3'(SLOT_R5)};
      OFF_REG6: slot_of = {1'b1, 3'(SLOT_R6)};
      OFF_REG7: slot_of = {1'b1, 3'(SLOT_R7)};
      OFF_REG8: slot_of = {1'b1, 3'(SLOT_R8)};
      default:  slot_of = 4'h0;
    endcase
  endfunction : slot_of

  always_comb
  begin
    {wr_hit, wr_slot} = slot_of(reg_addr);
    {rd_hit, rd_slot} = slot_of(reg_addr);
  end

  // Control bits and codes
  always_comb
  begin
    nxt_code = code_ff;
    nxt_on   = on_ff;
    nxt_dis  = dis_ff;
    if (clk_en && reg_wr && wr_hit)
    begin
      nxt_on[wr_slot]  = reg_wdata[BIT_ON];
      nxt_dis[wr_slot] = reg_wdata[BIT_DIS];
      if (wr_slot != 3'(SLOT_R7))
      begin
        nxt_code[wr_slot] = reg_wdata[CODE_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      code_ff <= {NREG{RST_CODE}};
      on_ff   <= {NREG{RST_ON}};
      dis_ff  <= {NREG{RST_DIS}};
    end
    else
    begin
      code_ff <= nxt_code;
      on_ff   <= nxt_on;
      dis_ff  <= nxt_dis;
    end
  end

  always_comb
  begin
    pin_req          = '0;
    pin_req[SLOT_R3] = power_keep_pin;
    pin_req[SLOT_R4] = oscillator_rail_pin;
    pin_req[SLOT_R5] = rx_rail_pin;
    pin_req[SLOT_R6] = tx_rail_pin;
    pin_req[SLOT_R7] = power_keep_pin;
    pin_req[SLOT_R8] = power_keep_pin;
  end

  // Status sampling, enables and read path
  always_comb
  begin
    nxt_ok     = ok_ff;
    nxt_en     = en_ff;
    nxt_rdata  = rdata_ff;
    nxt_rvalid = rvalid_ff;
    if (clk_en)
    begin
      nxt_ok     = in_regulation;
      nxt_en     = on_ff | (pin_req & {NREG{startup_done}});
      nxt_rvalid = reg_rd;
      if (reg_rd)
      begin
        nxt_rdata = 8'h00;
        if (rd_hit)
        begin
          nxt_rdata[BIT_DIS] = dis_ff[rd_slot];
          nxt_rdata[BIT_OK]  = ok_ff[rd_slot];
          nxt_rdata[BIT_ON]  = on_ff[rd_slot];
          nxt_rdata[CODE_W-1:0] = code_ff[rd_slot];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ok_ff     <= '0;
      en_ff     <= '0;
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      ok_ff     <= nxt_ok;
      en_ff     <= nxt_en;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  for (genvar i = 0; i < NREG; i++)
  begin : g_dec
    ldob_vdecode ldob_vdecode_inst (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .code      (code_ff[i]),
      .target_mv (target_mv[i])
    );
  end

  assign reg_rdata        = rdata_ff;
  assign reg_rvalid       = rvalid_ff;
  assign reg_enable       = en_ff;
  assign discharge_select = dis_ff;
  assign voltage_code     = code_ff;

  a_code_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr == OFF_REG3
      |=> code_ff[SLOT_R3] == $past(reg_wdata[4:0]))
    else $error("code write lost");

  a_on_to_enable: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr == OFF_REG4 && reg_wdata[5]
      ##1 clk_en |=> reg_enable[SLOT_R4])
    else $error("enable write did not reach regulator");

  a_ok_readback: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == OFF_REG5
      |=> reg_rvalid && reg_rdata[6] == $past(ok_ff[SLOT_R5]))
    else $error("status bit readback wrong");

  a_dis_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr == OFF_REG6
      |=> discharge_select[SLOT_R6] == $past(reg_wdata[7]))
    else $error("discharge select not written");

  a_r7_low_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_rd && reg_addr == OFF_REG7 |=> reg_rdata[4:0] == 5'h00)
    else $error("regulator 7 low bits not read-only");

  a_r8_map: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_wr && reg_addr == OFF_REG8
      |=> on_ff[SLOT_R8] == $past(reg_wdata[5])
          && dis_ff[SLOT_R8] == $past(reg_wdata[7]))
    else $error("regulator 8 bits misplaced");

  a_unmapped_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && reg_rd && !rd_hit |=> reg_rdata == 8'h00)
    else $error("unmapped address answered");

  a_band_base: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && code_ff[SLOT_R3] == 5'h1f |=> target_mv[SLOT_R3] == 12'he74)
    else $error("top code not 3.7 V");

  a_pin_gate: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && !startup_done && !on_ff[SLOT_R5] |=> !reg_enable[SLOT_R5])
    else $error("pin acted before start-up");

  a_ok_nowrite: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && !in_regulation[SLOT_R3] ##1 clk_en && reg_rd
      && reg_addr == OFF_REG3 |=> !reg_rdata[6])
    else $error("status bit took host write");
endmodule : ldob_bank

// ==== sim/ldob_host.sv ====
`timescale 1ns/1ns
module ldob_host
(
  // Clock
  input  wire logic       ref_clk,
  // Register requests towards the bank
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One strobe over one taking edge; idle lines then show the inverse
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : xfer
endmodule : ldob_host

// ==== sim/tb_ldob_bank.sv ====
`timescale 1ns/1ns
module tb_ldob_bank;
  import ldob_pkg::*;
  logic                           ref_clk, rst, clk_en, startup_done;
  logic [3:0]                     pins;
  logic [7:0]                     reg_addr, reg_wdata, reg_rdata;
  logic                           reg_wr, reg_rd, reg_rvalid;
  logic [NUM_REG-1:0]             in_regulation, reg_enable, dis_sel;
  logic [NUM_REG-1:0][CODE_W-1:0] voltage_code;
  logic [NUM_REG-1:0][MV_W-1:0]   target_mv;
  logic [7:0]                     exp_q[$];
  logic [7:0]                     wbyte[NUM_REG];
  logic [7:0] addr_of[NUM_REG] = '{8'h0c, 8'h10, 8'h0d, 8'h11, 8'h0e, 8'h12};
  logic [5:0] pin_mask[4] = '{6'h02, 6'h04, 6'h08, 6'h31};
  int                             mismatches, num_checks, i;
  integer                         seed;

  ldob_bank ldob_bank_inst (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .startup_done(startup_done), .oscillator_rail_pin(pins[0]),
    .rx_rail_pin(pins[1]), .tx_rail_pin(pins[2]),
    .power_keep_pin(pins[3]), .in_regulation(in_regulation),
    .reg_enable(reg_enable), .discharge_select(dis_sel),
    .voltage_code(voltage_code), .target_mv(target_mv));
  ldob_host ldob_host_inst (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    ldob_host_inst.xfer(1'b0, a, 8'h00);
  endtask : rd

  function automatic logic [11:0] mv(input logic [4:0] c);
    logic [11:0] s;
    s = {9'h000, c[2:0]};
    case (c[4:3])
      2'b00: mv = 12'h578 + 12'h064 * s;
      2'b01: mv = 12'h866 + 12'h032 * s;
      2'b10: mv = 12'h9f6 + 12'h032 * s;
      default: mv = 12'hbb8 + 12'h064 * s;
    endcase
  endfunction : mv

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Whole sequence needs well under a thousand cycles
  initial
  begin
    #100000;
    mismatches++;
    tally_and_finish();
  end

  always @(posedge ref_clk)
  begin
    if (reg_rvalid === 1'b1)
      check("rdata", {4'h0, reg_rdata}, {4'h0, exp_q.pop_front()});
  end

  initial
  begin
    seed = 32'h8265;
    rst = 1'b1;
    clk_en = 1'b1;
    startup_done = 1'b0;
    pins = 4'h0;
    in_regulation = 6'h00;
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    for (i = 0; i < NUM_REG; i++)
      rd(addr_of[i], 8'h00);
    rd(8'h20, 8'h00);
    in_regulation = 6'($random(seed));
    for (i = 0; i < NUM_REG; i++)
    begin
      wbyte[i] = 8'($random(seed));
      ldob_host_inst.xfer(1'b1, addr_of[i], wbyte[i]);
    end
    ldob_host_inst.xfer(1'b1, 8'h20, 8'hff);
    repeat (3) @(posedge ref_clk);
    #1;
    // slot of regulator 7 drops its code
    for (i = 0; i < NUM_REG; i++)
    begin
      rd(addr_of[i], {wbyte[i][7], in_regulation[i], wbyte[i][5],
         (i == SLOT_R7) ? 5'h00 : wbyte[i][4:0]});
      check("code", 12'(voltage_code[i]),
            (i == SLOT_R7) ? 12'h000 : 12'(wbyte[i][4:0]));
      check("on", 12'(reg_enable[i]), 12'(wbyte[i][5]));
      check("dis", 12'(dis_sel[i]), 12'(wbyte[i][7]));
    end
    rd(8'h20, 8'h00);
    // every code through the band decode
    for (i = 0; i < 32; i++)
    begin
      ldob_host_inst.xfer(1'b1, 8'h0c, {3'h0, 5'(i)});
      repeat (2) @(posedge ref_clk);
      #1;
      check("mv", target_mv[SLOT_R3], mv(5'(i)));
    end
    // A write while clk_en is low must leave the code and discharge select as they were
    ldob_host_inst.xfer(1'b1, 8'h10, 8'ha5);
    repeat (2) @(posedge ref_clk);
    #1;
    check("on4", 12'(reg_enable[SLOT_R4]), 12'h001);
    clk_en = 1'b0;
    ldob_host_inst.xfer(1'b1, 8'h10, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1;
    check("frz_code", 12'(voltage_code[SLOT_R4]), 12'h005);
    check("frz_dis", 12'(dis_sel[SLOT_R4]), 12'h001);
    clk_en = 1'b1;
    // Mid-run reset returns every control to its reset value
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    check("rst_code", 12'(voltage_code[SLOT_R4]), 12'h000);
    check("rst_on", 12'(reg_enable), 12'h000);
    repeat (2) @(posedge ref_clk);
    #1;
    check("rst_mv", target_mv[SLOT_R3], 12'h578);
    check("rst_dis", 12'(dis_sel), 12'h000);
    for (i = 0; i < NUM_REG; i++)
      ldob_host_inst.xfer(1'b1, addr_of[i], 8'h00);
    pins = 4'hf;
    repeat (3) @(posedge ref_clk);
    #1;
    check("gated", 12'(reg_enable), 12'h000);
    startup_done = 1'b1;
    // each pin reaches its own regulators
    for (i = 0; i < 4; i++)
    begin
      pins = 4'(1 << i);
      repeat (3) @(posedge ref_clk);
      #1;
      check("pin", 12'(reg_enable), 12'(pin_mask[i]));
    end
    repeat (3) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule : tb_ldob_bank
